// ### flash_config_reg1_protection.sv
// Operation
// - Protection source select ships 0, non-volatile protect bits ship 000.
// - Source 0: status write updates non-volatile protect bits, taking the long write time.
// - Setting source to 1 programs non-volatile bits 111; volatile reload them on reset.
// - Source 1: status write updates volatile protect bits only, short write time unless it carries config or changes the write-disable bit.
// - One-time bits stay 1 when written 0, without program error.
// - Parameter location 1 places small sectors at top, 0 at bottom; ships 0.
// - Uniform sector layout makes parameter location meaningless.
// - Protection direction and parameter location are set independently.
// - Four-lane default loads volatile four-lane; wide-instruction NV sets it to 1.
// - Four-wide instruction mode refuses clearing either four-lane bit.
// - Lock default is fixed and supplies the power-on lock value.
// - Volatile direction, source and location mirror their one-time counterparts.
// - Four-lane mode: protect pin becomes data, lane three resets while deselected.
// - Four-lane mode keeps single and dual reads working without those pins.
// - Writing the non-volatile four-lane bit also writes the volatile one.
// - Lock freezes both protect copies, one-time bits and the one-time area.
// - Locked writes leave frozen bits unchanged and raise no error.
// - Locked one-time area program fails and sets program error.
// - Lock clears only on power cycle or hardware reset, not software reset.
// - Lock may be set in the same write that changes other bits.
// - Lock does not block write-disable or four-lane bits.
// - Protection direction 1 starts at low address, 0 at high address.
module flash_config_reg1_protection
  import flash_cfg_pkg::*;
#(
  parameter int NV_WRITE_CYCLES = T_W_CYCLES,
  parameter int OTP_SIZE = OTP_BYTES
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_link_clk,
  input wire logic i_cmd_valid,
  input wire cmd_s i_cmd,
  output logic o_cmd_ready,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  input wire logic i_cs_n,
  input wire logic i_wp_n,
  input wire logic i_lane3,
  input wire logic i_uniform_sectors,
  output logic [2:0] o_block_protect,
  output logic o_protect_from_low,
  output logic o_param_at_top,
  output logic o_protect_source_mirror,
  output logic o_four_lane,
  output logic o_four_wide_instruction_mode,
  output logic o_locked,
  output logic o_busy,
  output logic o_wp_active,
  output logic o_lane23_data,
  output logic o_otp_program,
  output logic [23:0] o_otp_addr
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [7:0] read_reg(input logic [23:0] a, input core_s s);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      ADDR_STATUS_ONE_NONVOLATILE: begin
        r[SR_SRWD] = s.status_write_disable_nv;
        r[SR_BP_LO +: 3] = s.nonvol_block_protect;
      end
      ADDR_STATUS_ONE_VOLATILE: begin
        r[SR_SRWD] = s.status_write_disable_nv;
        r[SR_PERR] = s.p_err;
        r[SR_BP_LO +: 3] = s.vol_block_protect;
        r[SR_BUSY] = (s.busy_cnt != 16'h0000);
      end
      ADDR_CONFIG_ONE_NONVOLATILE, ADDR_CONFIG_ONE_VOLATILE: begin
        r[CR1_DIR] = s.protect_direction_otp;
        r[CR1_SRC] = s.protect_source_otp;
        r[CR1_PARAM] = s.param_location_otp;
        r[CR1_QUAD] = (a == ADDR_CONFIG_ONE_VOLATILE) ? s.four_lane : s.four_lane_default;
        r[CR1_LOCK] = (a == ADDR_CONFIG_ONE_VOLATILE) ? s.lock : LOCK_DEFAULT;
      end
      ADDR_CONFIG_TWO_NONVOLATILE: r[CR2_QPI] = s.qpi_nv;
      ADDR_CONFIG_TWO_VOLATILE: r[CR2_QPI] = s.qpi_v;
      default: r = 8'h00;
    endcase
    return r;
  endfunction : read_reg

  // Non-volatile configuration write: one-time bits only ever set
  function automatic core_s write_cr1_nv(input core_s s, input logic [7:0] d);
    core_s r;
    r = s;
    if (!s.lock) begin
      r.protect_direction_otp = s.protect_direction_otp | d[CR1_DIR];
      r.param_location_otp = s.param_location_otp | d[CR1_PARAM];
      r.protect_source_otp = s.protect_source_otp | d[CR1_SRC];
      if (d[CR1_SRC] && !s.protect_source_otp) begin
        r.nonvol_block_protect = BP_ALL;
      end
    end
    if (d[CR1_QUAD] || !s.qpi_v) begin
      r.four_lane_default = d[CR1_QUAD];
      r.four_lane = d[CR1_QUAD];
    end
    return r;
  endfunction : write_cr1_nv

  function automatic core_s reload(input core_s s, input logic hard);
    core_s r;
    r = s;
    r.vol_block_protect = s.nonvol_block_protect;
    r.four_lane = s.four_lane_default;
    r.qpi_v = s.qpi_nv;
    r.p_err = 1'b0;
    if (hard) begin
      r.lock = LOCK_DEFAULT;
    end
    return r;
  endfunction : reload

  // ****************************************************************
  // Link domain
  // ****************************************************************
  link_s link_ff, nxt_link;
  core_s core_ff, nxt_core;

  assign o_cmd_ready = (link_ff.req_tog == link_ff.ack_s2);
  assign o_rd_data = link_ff.rd_data;
  assign o_rd_valid = link_ff.rd_valid;

  always_comb begin
    nxt_link = link_ff;
    nxt_link.ack_s1 = core_ff.ack_tog;
    nxt_link.ack_s2 = link_ff.ack_s1;
    nxt_link.ack_s3 = link_ff.ack_s2;
    nxt_link.rd_valid = 1'b0;
    if ((link_ff.ack_s2 != link_ff.ack_s3) && (link_ff.cmd.kind == CMD_ANY_READ)) begin
      nxt_link.rd_data = core_ff.rd_data;
      nxt_link.rd_valid = 1'b1;
    end
    if (i_cmd_valid && o_cmd_ready) begin
      nxt_link.cmd = i_cmd;
      nxt_link.req_tog = ~link_ff.req_tog;
    end
  end

  always_ff @(posedge i_link_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      link_ff <= '0;
    end else begin
      link_ff <= nxt_link;
    end
  end

  // ****************************************************************
  // Core domain
  // ****************************************************************
  logic take;
  logic idle;
  logic soft_evt;
  logic hw_evt;
  logic wr_evt;
  logic otp_evt;
  logic vol_start;
  logic nv_start;
  cmd_s cmd;

  assign cmd = link_ff.cmd;
  assign take = core_ff.req_s2 != core_ff.req_s3;
  assign idle = core_ff.busy_cnt == 16'h0000;
  // Lane three acts as reset only while deselected in four-lane mode
  assign hw_evt = core_ff.four_lane & core_ff.cs_s2 & ~core_ff.lane3_s2;

  always_comb begin
    nxt_core = core_ff;
    soft_evt = 1'b0;
    wr_evt = 1'b0;
    otp_evt = 1'b0;
    vol_start = 1'b0;
    nv_start = 1'b0;
    nxt_core.req_s1 = link_ff.req_tog;
    nxt_core.req_s2 = core_ff.req_s1;
    nxt_core.req_s3 = core_ff.req_s2;
    nxt_core.cs_s1 = i_cs_n;
    nxt_core.cs_s2 = core_ff.cs_s1;
    nxt_core.lane3_s1 = i_lane3;
    nxt_core.lane3_s2 = core_ff.lane3_s1;
    nxt_core.wp_s1 = i_wp_n;
    nxt_core.wp_s2 = core_ff.wp_s1;
    nxt_core.uni_s1 = i_uniform_sectors;
    nxt_core.uni_s2 = core_ff.uni_s1;
    nxt_core.otp_go = 1'b0;
    if (!idle) begin
      nxt_core.busy_cnt = core_ff.busy_cnt - 16'h0001;
    end
    if (take) begin
      nxt_core.ack_tog = ~core_ff.ack_tog;
      case (cmd.kind)
        CMD_STATUS_WRITE: begin
          if (idle) begin
            wr_evt = 1'b1;
            nxt_core.status_write_disable_nv = cmd.data[SR_SRWD];
            if (!core_ff.lock) begin
              nxt_core.vol_block_protect = cmd.data[SR_BP_LO +: 3];
              if (!core_ff.protect_source_otp) begin
                nxt_core.nonvol_block_protect = cmd.data[SR_BP_LO +: 3];
              end
            end
            if (cmd.cfg_present) begin
              nxt_core = write_cr1_nv(nxt_core, cmd.cfg_data);
              nxt_core.lock = core_ff.lock | cmd.cfg_data[CR1_LOCK];
            end
            if (cmd.cfg_present || !core_ff.protect_source_otp
                || (cmd.data[SR_SRWD] != core_ff.status_write_disable_nv)) begin
              nv_start = 1'b1;
            end else begin
              vol_start = 1'b1;
            end
          end
        end
        CMD_ANY_WRITE: begin
          if (idle) begin
            wr_evt = 1'b1;
            case (cmd.addr)
              ADDR_STATUS_ONE_NONVOLATILE: begin
                nv_start = 1'b1;
                nxt_core.status_write_disable_nv = cmd.data[SR_SRWD];
                if (!core_ff.lock) begin
                  nxt_core.nonvol_block_protect = cmd.data[SR_BP_LO +: 3];
                end
              end
              ADDR_STATUS_ONE_VOLATILE: begin
                vol_start = 1'b1;
                if (!core_ff.lock) begin
                  nxt_core.vol_block_protect = cmd.data[SR_BP_LO +: 3];
                end
              end
              ADDR_CONFIG_ONE_NONVOLATILE: begin
                nv_start = 1'b1;
                nxt_core = write_cr1_nv(nxt_core, cmd.data);
              end
              ADDR_CONFIG_ONE_VOLATILE: begin
                vol_start = 1'b1;
                if (cmd.data[CR1_QUAD] || !core_ff.qpi_v) begin
                  nxt_core.four_lane = cmd.data[CR1_QUAD];
                end
                nxt_core.lock = core_ff.lock | cmd.data[CR1_LOCK];
              end
              ADDR_CONFIG_TWO_NONVOLATILE: begin
                nv_start = 1'b1;
                if (cmd.data[CR2_QPI]) begin
                  nxt_core.qpi_nv = 1'b1;
                  nxt_core.four_lane_default = 1'b1;
                end
              end
              ADDR_CONFIG_TWO_VOLATILE: begin
                vol_start = 1'b1;
                nxt_core.qpi_v = cmd.data[CR2_QPI];
              end
              default: wr_evt = 1'b0;
            endcase
          end
        end
        CMD_ANY_READ: begin
          nxt_core.rd_data = read_reg(cmd.addr, core_ff);
        end
        CMD_OTP_PROGRAM: begin
          if (idle) begin
            otp_evt = 1'b1;
            if (core_ff.lock || (cmd.addr >= 24'(OTP_SIZE))) begin
              nxt_core.p_err = 1'b1;
            end else begin
              nv_start = 1'b1;
              nxt_core.otp_go = 1'b1;
              nxt_core.otp_addr = cmd.addr;
            end
          end
        end
        CMD_SOFT_RESET: begin
          soft_evt = 1'b1;
          // Reload the next state so synchronisers, timer and acknowledge keep running
          nxt_core = reload(nxt_core, 1'b0);
        end
        default: nxt_core.ack_tog = ~core_ff.ack_tog;
      endcase
      if (nv_start) begin
        nxt_core.busy_cnt = 16'(NV_WRITE_CYCLES);
      end else if (vol_start) begin
        nxt_core.busy_cnt = 16'(T_CS_CYCLES);
      end
    end
    if (hw_evt) begin
      nxt_core = reload(nxt_core, 1'b1);
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      core_ff <= '0;
      core_ff.cs_s1 <= 1'b1;
      core_ff.cs_s2 <= 1'b1;
      core_ff.lane3_s1 <= 1'b1;
      core_ff.lane3_s2 <= 1'b1;
      core_ff.wp_s1 <= 1'b1;
      core_ff.wp_s2 <= 1'b1;
      core_ff.nonvol_block_protect <= BP_SHIP;
      core_ff.vol_block_protect <= BP_SHIP;
      core_ff.protect_source_otp <= OTP_BIT_SHIP;
      core_ff.param_location_otp <= OTP_BIT_SHIP;
      core_ff.protect_direction_otp <= OTP_BIT_SHIP;
      core_ff.four_lane_default <= QUAD_SHIP;
      core_ff.four_lane <= QUAD_SHIP;
      core_ff.lock <= LOCK_DEFAULT;
    end else begin
      core_ff <= nxt_core;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_block_protect = core_ff.vol_block_protect;
  assign o_protect_from_low = core_ff.protect_direction_otp;
  assign o_param_at_top = core_ff.param_location_otp & ~core_ff.uni_s2;
  assign o_protect_source_mirror = core_ff.protect_source_otp;
  assign o_four_lane = core_ff.four_lane;
  assign o_four_wide_instruction_mode = core_ff.qpi_v;
  assign o_locked = core_ff.lock;
  assign o_busy = ~idle;
  // Protect pin is ignored and inactive in four-lane mode
  assign o_wp_active = ~core_ff.four_lane & ~core_ff.wp_s2;
  assign o_lane23_data = core_ff.four_lane & ~core_ff.cs_s2;
  assign o_otp_program = core_ff.otp_go;
  assign o_otp_addr = core_ff.otp_addr;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  a_lock_freezes_bp: assert property (core_ff.lock && !soft_evt |=>
      $stable(core_ff.nonvol_block_protect) && (hw_evt || $past(hw_evt) ||
      $stable(core_ff.vol_block_protect)))
    else $error("protect bits changed while locked");
  a_otp_sticky_bit: assert property (core_ff.protect_source_otp |=> core_ff.protect_source_otp)
    else $error("one-time bit cleared");
  a_source_sets_all: assert property ($rose(core_ff.protect_source_otp) |->
      core_ff.nonvol_block_protect == BP_ALL)
    else $error("source set without all protect bits");
  a_qpi_keeps_quad: assert property (core_ff.qpi_v && core_ff.four_lane && !hw_evt && !soft_evt |=>
      core_ff.four_lane && core_ff.four_lane_default >= $past(core_ff.four_lane_default))
    else $error("four-lane cleared in four-wide mode");
  a_soft_keeps_lock: assert property (soft_evt && !hw_evt |=> core_ff.lock == $past(core_ff.lock))
    else $error("software reset changed lock");
  a_hard_reload_vol: assert property (hw_evt |=> core_ff.lock == LOCK_DEFAULT &&
      core_ff.four_lane == core_ff.four_lane_default)
    else $error("hardware reset did not reload");
  a_vol_write_time: assert property (vol_start |=> o_busy [*7] ##1 !o_busy)
    else $error("volatile write time wrong");
  a_locked_otp_fail: assert property (otp_evt && core_ff.lock |=> core_ff.p_err && !o_otp_program)
    else $error("locked one-time program not failed");
  a_write_no_error: assert property (wr_evt && !hw_evt |=> core_ff.p_err == $past(core_ff.p_err))
    else $error("register write raised error");

  c_lock_set: cover property ($rose(core_ff.lock));
  c_source_set: cover property ($rose(core_ff.protect_source_otp));
  c_otp_fail: cover property (otp_evt && core_ff.lock);
  c_read_done: cover property (@(posedge i_link_clk) o_rd_valid);
  c_hw_reload: cover property (hw_evt);

endmodule : flash_config_reg1_protection

// ### flash_cfg_pkg.sv
package flash_cfg_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned T_CS_NS = 50;
  localparam int unsigned T_W_US = 100;
  localparam int unsigned T_CS_CYCLES = (T_CS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned T_W_CYCLES = (T_W_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OTP_BYTES = 1024;

  // ****************************************************************
  // Register addresses for the any-register commands
  // ****************************************************************
  localparam logic [23:0] ADDR_STATUS_ONE_NONVOLATILE = 24'h000000;
  localparam logic [23:0] ADDR_CONFIG_ONE_NONVOLATILE = 24'h000002;
  localparam logic [23:0] ADDR_CONFIG_TWO_NONVOLATILE = 24'h000003;
  localparam logic [23:0] ADDR_STATUS_ONE_VOLATILE = 24'h800000;
  localparam logic [23:0] ADDR_CONFIG_ONE_VOLATILE = 24'h800002;
  localparam logic [23:0] ADDR_CONFIG_TWO_VOLATILE = 24'h800003;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned SR_SRWD = 7;
  localparam int unsigned SR_PERR = 6;
  localparam int unsigned SR_BP_LO = 2;
  localparam int unsigned SR_BUSY = 0;
  localparam int unsigned CR1_DIR = 5;
  localparam int unsigned CR1_SRC = 3;
  localparam int unsigned CR1_PARAM = 2;
  localparam int unsigned CR1_QUAD = 1;
  localparam int unsigned CR1_LOCK = 0;
  localparam int unsigned CR2_QPI = 6;

  // ****************************************************************
  // Ship and reset values
  // ****************************************************************
  localparam logic [2:0] BP_SHIP = 3'h0;
  localparam logic [2:0] BP_ALL = 3'h7;
  localparam logic LOCK_DEFAULT = 1'h0;
  localparam logic OTP_BIT_SHIP = 1'h0;
  localparam logic QUAD_SHIP = 1'h0;

  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_STATUS_WRITE = 3'h1,
    CMD_ANY_WRITE = 3'h2,
    CMD_ANY_READ = 3'h3,
    CMD_OTP_PROGRAM = 3'h4,
    CMD_SOFT_RESET = 3'h5
  } cmd_kind_e;

  typedef struct packed {
    cmd_kind_e kind;
    logic [23:0] addr;
    logic [7:0] data;
    logic cfg_present;
    logic [7:0] cfg_data;
  } cmd_s;

  typedef struct packed {
    logic req_s1, req_s2, req_s3;
    logic ack_tog;
    logic cs_s1, cs_s2, lane3_s1, lane3_s2, wp_s1, wp_s2;
    logic uni_s1, uni_s2;
    logic status_write_disable_nv;
    logic [2:0] nonvol_block_protect;
    logic [2:0] vol_block_protect;
    logic p_err;
    logic protect_direction_otp, protect_source_otp, param_location_otp;
    logic four_lane_default, four_lane, lock;
    logic qpi_nv, qpi_v;
    logic [15:0] busy_cnt;
    logic [7:0] rd_data;
    logic otp_go;
    logic [23:0] otp_addr;
  } core_s;

  typedef struct packed {
    logic req_tog;
    cmd_s cmd;
    logic ack_s1, ack_s2, ack_s3;
    logic [7:0] rd_data;
    logic rd_valid;
  } link_s;

endpackage : flash_cfg_pkg

// ### host_model.sv
module host_model
  import flash_cfg_pkg::*;
(
  input wire logic i_link_clk,
  input wire logic i_cmd_ready,
  input wire logic i_rd_valid,
  input wire logic [7:0] i_rd_data,
  output logic o_cmd_valid,
  output cmd_s o_cmd
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_cmd_valid = 1'h0;
    o_cmd = '0;
  end

  // ****************************************************************
  // One command: offer, hold until taken, collect a read answer
  // ****************************************************************
  task automatic send(input cmd_s c, output logic [7:0] rd, output bit ok);
    logic seen;
    int n;
    ok = 1'b0;
    rd = 8'h00;
    @(posedge i_link_clk);
    o_cmd_valid <= 1'h1;
    o_cmd <= c;
    for (n = 0; n < 64 && !ok; n++) begin
      @(negedge i_link_clk);
      seen = i_cmd_ready;
      @(posedge i_link_clk);
      ok = seen;
    end
    // Released lines show the inverse so a stale command never looks live
    o_cmd_valid <= 1'h0;
    o_cmd <= ~c;
    if (ok && c.kind == CMD_ANY_READ) begin
      ok = 1'b0;
      for (n = 0; n < 64 && !ok; n++) begin
        @(negedge i_link_clk);
        ok = i_rd_valid;
        rd = i_rd_data;
      end
    end
  endtask : send
endmodule : host_model

// ### tb.sv
module tb
  import flash_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic i_clk, i_reset_n, i_link_clk, i_cmd_valid, o_cmd_ready, o_rd_valid;
  cmd_s i_cmd;
  logic [7:0] o_rd_data;
  logic i_cs_n, i_wp_n, i_lane3, i_uniform_sectors;
  logic [2:0] o_block_protect;
  logic o_protect_from_low, o_param_at_top, o_protect_source_mirror, o_four_lane;
  logic o_four_wide_instruction_mode, o_locked, o_busy, o_wp_active, o_lane23_data, o_otp_program;
  logic [23:0] o_otp_addr;
  logic [23:0] otp_seen = 24'h000000;
  logic [7:0] otp_cnt = 8'h00;
  logic [7:0] junk;
  logic last_busy;
  int fails, n_checks;

  flash_config_reg1_protection #(.NV_WRITE_CYCLES(200), .OTP_SIZE(1024)) flash_config_reg1_protection_inst (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_link_clk(i_link_clk), .i_cmd_valid(i_cmd_valid),
    .i_cmd(i_cmd), .o_cmd_ready(o_cmd_ready), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
    .i_cs_n(i_cs_n), .i_wp_n(i_wp_n), .i_lane3(i_lane3), .i_uniform_sectors(i_uniform_sectors),
    .o_block_protect(o_block_protect), .o_protect_from_low(o_protect_from_low),
    .o_param_at_top(o_param_at_top), .o_protect_source_mirror(o_protect_source_mirror),
    .o_four_lane(o_four_lane), .o_four_wide_instruction_mode(o_four_wide_instruction_mode),
    .o_locked(o_locked), .o_busy(o_busy), .o_wp_active(o_wp_active), .o_lane23_data(o_lane23_data),
    .o_otp_program(o_otp_program), .o_otp_addr(o_otp_addr));

  host_model host_model_inst (.i_link_clk(i_link_clk), .i_cmd_ready(o_cmd_ready), .i_rd_valid(o_rd_valid),
    .i_rd_data(o_rd_data), .o_cmd_valid(i_cmd_valid), .o_cmd(i_cmd));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  initial begin
    i_link_clk = 1'b0;
    #3;
    forever begin
      i_link_clk = ~i_link_clk;
      #16;
    end
  end

  always @(negedge i_clk) begin
    if (o_otp_program === 1'b1) begin
      otp_cnt <= otp_cnt + 8'h01;
      otp_seen <= o_otp_addr;
    end
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  function automatic logic [7:0] pins();
    return {o_locked, o_four_lane, o_four_wide_instruction_mode, o_protect_from_low, o_param_at_top, o_block_protect};
  endfunction : pins

  task automatic run(input cmd_kind_e k, input logic [23:0] a, input logic [7:0] d, input logic cp,
                     input logic [7:0] cfg, output logic [7:0] rd);
    cmd_s c;
    bit ok;
    int n;
    c = '{k, a, d, cp, cfg};
    host_model_inst.send(c, rd, ok);
    @(negedge i_link_clk);
    for (n = 0; n < 100 && o_cmd_ready !== 1'b1; n++) @(negedge i_link_clk);
    last_busy = o_busy;
    for (n = 0; n < 400 && o_busy !== 1'b0; n++) @(negedge i_clk);
    @(negedge i_clk);
    if (!ok || o_busy !== 1'b0 || o_cmd_ready !== 1'b1) begin
      fails++;
      $display("ERROR handshake expected done seen stalled");
      tally_and_finish();
    end
  endtask : run

  task automatic wr(input logic [23:0] a, input logic [7:0] d);
    logic [7:0] rd;
    run(CMD_ANY_WRITE, a, d, 1'b0, 8'h00, rd);
  endtask : wr

  task automatic rdc(input string nm, input logic [23:0] a, input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] rd;
    run(CMD_ANY_READ, a, 8'h00, 1'b0, 8'h00, rd);
    chk(nm, exp, rd & m);
  endtask : rdc

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    {i_reset_n, i_cs_n, i_wp_n, i_lane3, i_uniform_sectors} = 5'b01110;
    fails = 0;
    n_checks = 0;
    repeat (5) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(negedge i_clk);
    chk("outputs", 8'h00, pins());
    chk("source", 8'h00, {7'h0, o_protect_source_mirror});
    @(posedge i_clk);
    i_wp_n <= 1'b0;
    repeat (3) @(negedge i_clk);
    chk("pin roles", 8'h02, {6'h0, o_wp_active, o_lane23_data});
    @(posedge i_clk);
    i_wp_n <= 1'b1;
    rdc("config_one_nonvolatile", ADDR_CONFIG_ONE_NONVOLATILE, 8'hff, 8'h00);
    rdc("status_one_nonvolatile", ADDR_STATUS_ONE_NONVOLATILE, 8'h1c, 8'h00);
    $display("test reset done");
    run(CMD_STATUS_WRITE, 24'h0, 8'h14, 1'b0, 8'h00, junk);
    chk("busy", 8'h01, {7'h0, last_busy});
    chk("outputs", 8'h05, pins());
    rdc("status_one_nonvolatile", ADDR_STATUS_ONE_NONVOLATILE, 8'h1c, 8'h14);
    $display("test nonvolatile protect done");
    wr(ADDR_CONFIG_ONE_NONVOLATILE, 8'h20);
    chk("outputs", 8'h15, pins());
    rdc("config_one_volatile", ADDR_CONFIG_ONE_VOLATILE, 8'h2c, 8'h20);
    wr(ADDR_CONFIG_ONE_NONVOLATILE, 8'h04);
    chk("outputs", 8'h1d, pins());
    rdc("config_one_nonvolatile", ADDR_CONFIG_ONE_NONVOLATILE, 8'hff, 8'h24);
    rdc("status_one_volatile", ADDR_STATUS_ONE_VOLATILE, 8'h40, 8'h00);
    @(posedge i_clk);
    i_uniform_sectors <= 1'b1;
    repeat (3) @(negedge i_clk);
    chk("outputs", 8'h15, pins());
    @(posedge i_clk);
    i_uniform_sectors <= 1'b0;
    $display("test one-time bits done");
    run(CMD_STATUS_WRITE, 24'h0, 8'h14, 1'b1, 8'h02, junk);
    chk("outputs", 8'h5d, pins());
    rdc("config_one_nonvolatile", ADDR_CONFIG_ONE_NONVOLATILE, 8'hff, 8'h26);
    @(posedge i_clk);
    i_wp_n <= 1'b0;
    i_cs_n <= 1'b0;
    repeat (4) @(negedge i_clk);
    chk("pin roles", 8'h01, {6'h0, o_wp_active, o_lane23_data});
    @(posedge i_clk);
    i_wp_n <= 1'b1;
    i_cs_n <= 1'b1;
    wr(ADDR_CONFIG_TWO_VOLATILE, 8'h40);
    chk("outputs", 8'h7d, pins());
    wr(ADDR_CONFIG_ONE_VOLATILE, 8'h00);
    chk("outputs", 8'h7d, pins());
    wr(ADDR_CONFIG_ONE_NONVOLATILE, 8'h24);
    rdc("config_one_nonvolatile", ADDR_CONFIG_ONE_NONVOLATILE, 8'hff, 8'h26);
    wr(ADDR_CONFIG_TWO_VOLATILE, 8'h00);
    wr(ADDR_CONFIG_ONE_VOLATILE, 8'h00);
    chk("outputs", 8'h1d, pins());
    $display("test four lane done");
    wr(ADDR_CONFIG_ONE_NONVOLATILE, 8'h2e);
    rdc("status_one_nonvolatile", ADDR_STATUS_ONE_NONVOLATILE, 8'h1c, 8'h1c);
    rdc("config_one_volatile", ADDR_CONFIG_ONE_VOLATILE, 8'h2c, 8'h2c);
    chk("source", 8'h01, {7'h0, o_protect_source_mirror});
    run(CMD_STATUS_WRITE, 24'h0, 8'h08, 1'b0, 8'h00, junk);
    chk("busy", 8'h00, {7'h0, last_busy});
    chk("protect", 8'h02, {5'h0, o_block_protect});
    rdc("status_one_nonvolatile", ADDR_STATUS_ONE_NONVOLATILE, 8'h1c, 8'h1c);
    run(CMD_SOFT_RESET, 24'h0, 8'h00, 1'b0, 8'h00, junk);
    chk("outputs", 8'h5f, pins());
    $display("test volatile protect done");
    run(CMD_OTP_PROGRAM, 24'h10, 8'ha5, 1'b0, 8'h00, junk);
    chk("otp pulses", 8'h01, otp_cnt);
    chk("otp addr", 8'h10, otp_seen[7:0]);
    wr(ADDR_CONFIG_ONE_VOLATILE, 8'h03);
    chk("outputs", 8'hdf, pins());
    run(CMD_STATUS_WRITE, 24'h0, 8'h8c, 1'b0, 8'h00, junk);
    chk("outputs", 8'hdf, pins());
    wr(ADDR_STATUS_ONE_VOLATILE, 8'h00);
    wr(ADDR_STATUS_ONE_NONVOLATILE, 8'h80);
    rdc("status_one_nonvolatile", ADDR_STATUS_ONE_NONVOLATILE, 8'h9c, 8'h9c);
    rdc("status_one_volatile", ADDR_STATUS_ONE_VOLATILE, 8'hff, 8'h9c);
    run(CMD_OTP_PROGRAM, 24'h20, 8'h5a, 1'b0, 8'h00, junk);
    chk("otp pulses", 8'h01, otp_cnt);
    rdc("status_one_volatile", ADDR_STATUS_ONE_VOLATILE, 8'h40, 8'h40);
    run(CMD_SOFT_RESET, 24'h0, 8'h00, 1'b0, 8'h00, junk);
    chk("outputs", 8'hdf, pins());
    @(posedge i_clk);
    i_lane3 <= 1'b0;
    repeat (6) @(negedge i_clk);
    @(posedge i_clk);
    i_lane3 <= 1'b1;
    repeat (4) @(negedge i_clk);
    chk("outputs", 8'h5f, pins());
    rdc("status_one_volatile", ADDR_STATUS_ONE_VOLATILE, 8'hff, 8'h9c);
    $display("test lock done");
    wr(ADDR_CONFIG_ONE_NONVOLATILE, 8'h00);
    wr(ADDR_CONFIG_TWO_NONVOLATILE, 8'h40);
    rdc("config_one_nonvolatile", ADDR_CONFIG_ONE_NONVOLATILE, 8'h02, 8'h02);
    rdc("config_two_nonvolatile", ADDR_CONFIG_TWO_NONVOLATILE, 8'h40, 8'h40);
    run(CMD_SOFT_RESET, 24'h0, 8'h00, 1'b0, 8'h00, junk);
    chk("outputs", 8'h7f, pins());
    $display("test quad default done");
    tally_and_finish();
  end
endmodule : tb
